// [verilog/btsc_consts.svh]
// constants for the bit-test-skip and call decode block
// Summary of operation
// - bit test takes 5-bit register address and 3-bit bit selector
// - taken skip flushes the fetched instruction, runs a no-op instead
// - call pushes current program counter plus one onto stack top
// - call loads 8-bit literal into program counter bits 7 to 0
// - call loads program counter bits 10:9 from status bits 6:5
// - call forces program counter bit 8 to zero
// - call is one word and always takes two cycles
`ifndef BTSC_CONSTS_SVH
`define BTSC_CONSTS_SVH
`define BTSC_OP_TEST    4'h7
`define BTSC_OP_CALL    4'h9
`define BTSC_NOP_WORD   12'h000
`define BTSC_PC_RESET   11'h7ff
`define BTSC_PAGE_HI    6
`define BTSC_PAGE_LO    5
`endif

// [verilog/btsc_pkg.sv]
// types for the bit-test-skip and call decode block
package btsc_pkg;
    typedef logic [11:0] btsc_word_t;
    typedef logic [10:0] btsc_pc_t;
    typedef enum logic [1:0] {
        BTSC_KIND_OTHER,
        BTSC_KIND_TEST,
        BTSC_KIND_CALL
    } btsc_kind_t;
endpackage

// [verilog/btsc_bit_pick.sv]
// selects one bit of a register byte
`timescale 1ns/100ps
module btsc_bit_pick #(
    parameter int WIDTH = 8
) (
    // data and selector
    input  wire logic [WIDTH-1:0]         value,
    input  wire logic [$clog2(WIDTH)-1:0] sel,
    // picked bit
    output wire logic                     bit_out
);
    assign bit_out = value[sel];
endmodule

// [verilog/btsc_decode.sv]
// decode and execute of bit-test-skip-if-set and subroutine call
`timescale 1ns/100ps
`include "btsc_consts.svh"
module btsc_decode (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // instruction in execute and the register byte it addressed
    input  wire btsc_pkg::btsc_word_t instr,
    input  wire logic             instr_valid,
    input  wire logic [7:0]       file_data,
    input  wire logic [7:0]       status,
    input  wire btsc_pkg::btsc_pc_t pc,
    // register file address for the bit test
    output wire logic [4:0]       file_addr,
    // stack push
    output logic                  push,
    output btsc_pkg::btsc_pc_t    return_stack_top,
    // program counter load
    output logic                  pc_load,
    output btsc_pkg::btsc_pc_t    pc_target,
    // flush of the fetched word, and the word to execute instead
    output logic                  flush,
    output wire btsc_pkg::btsc_word_t exec_word,
    output wire btsc_pkg::btsc_kind_t kind
);
    import btsc_pkg::*;

    wire logic [3:0] opcode   = instr[11:8];
    wire logic [2:0] bit_sel  = instr[7:5];
    wire logic [7:0] literal  = instr[7:0];
    wire logic       flushing = flush;
    // a flushed slot executes as no-op so it can never chain a second skip
    wire logic       is_test  = instr_valid && !flushing &&
                                opcode == `BTSC_OP_TEST;
    wire logic       is_call  = instr_valid && !flushing &&
                                opcode == `BTSC_OP_CALL;
    wire logic       bit_val;
    wire logic       skip     = is_test && bit_val;

    assign file_addr = instr[4:0];
    assign exec_word = flushing ? `BTSC_NOP_WORD : instr;
    assign kind      = is_test ? BTSC_KIND_TEST :
                       is_call ? BTSC_KIND_CALL : BTSC_KIND_OTHER;

    btsc_bit_pick #(.WIDTH(8)) u_pick (
        .value   (file_data),
        .sel     (bit_sel),
        .bit_out (bit_val)
    );

    wire btsc_pc_t next_ret    = pc + 11'h001;
    wire btsc_pc_t next_target = {status[`BTSC_PAGE_HI],
                                  status[`BTSC_PAGE_LO],
                                  1'b0, literal};

    // status is only read; nothing here writes a flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            push             <= 1'b0;
            return_stack_top <= `BTSC_PC_RESET;
            pc_load          <= 1'b0;
            pc_target        <= `BTSC_PC_RESET;
            flush            <= 1'b0;
        end else begin
            push    <= is_call;
            pc_load <= is_call;
            flush   <= skip || is_call;
            if (is_call) begin
                return_stack_top <= next_ret;
                pc_target        <= next_target;
            end
        end
    end

    property p_skip_flush;
        @(posedge clk) disable iff (rst)
        skip |=> flush && exec_word == `BTSC_NOP_WORD;
    endproperty
    a_skip_flush: assert property (p_skip_flush)
        else $error("taken skip did not flush");

    property p_noskip;
        @(posedge clk) disable iff (rst)
        (is_test && !bit_val) |=> !flush;
    endproperty
    a_noskip: assert property (p_noskip)
        else $error("skip on clear bit");

    property p_push;
        @(posedge clk) disable iff (rst)
        is_call |=> push && return_stack_top == $past(pc) + 11'h001;
    endproperty
    a_push: assert property (p_push)
        else $error("bad return address");

    property p_low;
        @(posedge clk) disable iff (rst)
        is_call |=> pc_target[7:0] == $past(instr[7:0]);
    endproperty
    a_low: assert property (p_low)
        else $error("bad literal load");

    property p_page;
        @(posedge clk) disable iff (rst)
        is_call |=> pc_target[10:9] == $past(status[6:5]);
    endproperty
    a_page: assert property (p_page)
        else $error("bad page bits");

    property p_bit8;
        @(posedge clk) disable iff (rst)
        pc_load |-> !pc_target[8];
    endproperty
    a_bit8: assert property (p_bit8)
        else $error("bit 8 not cleared");

    sequence s_call_issue;
        is_call;
    endsequence
    sequence s_call_flush;
        flush && pc_load ##1 !pc_load;
    endsequence
    property p_two_cycle;
        @(posedge clk) disable iff (rst)
        s_call_issue |=> s_call_flush;
    endproperty
    a_two_cycle: assert property (p_two_cycle)
        else $error("call not two cycles");

    property p_addr;
        @(posedge clk) disable iff (rst)
        file_addr == instr[4:0] && bit_sel == instr[7:5];
    endproperty
    a_addr: assert property (p_addr)
        else $error("bad operand fields");

    property p_push_pulse;
        @(posedge clk) disable iff (rst)
        push |=> !push;
    endproperty
    a_push_pulse: assert property (p_push_pulse)
        else $error("push held beyond one cycle");

    property p_load_pair;
        @(posedge clk) disable iff (rst)
        push == pc_load;
    endproperty
    a_load_pair: assert property (p_load_pair)
        else $error("push and load split");

    property p_flush_once;
        @(posedge clk) disable iff (rst)
        flush |=> !flush;
    endproperty
    a_flush_once: assert property (p_flush_once)
        else $error("flush chained");

    property p_flushed_nop;
        @(posedge clk) disable iff (rst)
        flush |-> exec_word == `BTSC_NOP_WORD && kind == BTSC_KIND_OTHER;
    endproperty
    a_flushed_nop: assert property (p_flushed_nop)
        else $error("flushed slot not a no-op");

    property p_pass;
        @(posedge clk) disable iff (rst)
        !flush |-> exec_word == instr;
    endproperty
    a_pass: assert property (p_pass)
        else $error("word altered outside flush");

    property p_top_hold;
        @(posedge clk) disable iff (rst)
        !is_call |=> $stable(return_stack_top);
    endproperty
    a_top_hold: assert property (p_top_hold)
        else $error("stack top moved without call");

    property p_target_hold;
        @(posedge clk) disable iff (rst)
        !is_call |=> $stable(pc_target);
    endproperty
    a_target_hold: assert property (p_target_hold)
        else $error("target moved without call");

    property p_kind_test;
        @(posedge clk) disable iff (rst)
        is_test |-> kind == BTSC_KIND_TEST;
    endproperty
    a_kind_test: assert property (p_kind_test)
        else $error("test not reported");

    property p_kind_call;
        @(posedge clk) disable iff (rst)
        is_call |-> kind == BTSC_KIND_CALL;
    endproperty
    a_kind_call: assert property (p_kind_call)
        else $error("call not reported");

    property p_other_quiet;
        @(posedge clk) disable iff (rst)
        (instr_valid && !flush && opcode != `BTSC_OP_TEST &&
         opcode != `BTSC_OP_CALL) |=> !flush && !push;
    endproperty
    a_other_quiet: assert property (p_other_quiet)
        else $error("other opcode acted");

    property p_no_valid;
        @(posedge clk) disable iff (rst)
        !instr_valid |=> !flush && !push;
    endproperty
    a_no_valid: assert property (p_no_valid)
        else $error("idle slot acted");
endmodule

// [dv/bit_test_skip_and_call_decode_bench.sv]
// self-checking bench for the bit-test-skip and call decode block
`timescale 1ns/100ps
module bit_test_skip_and_call_decode_bench;
    import btsc_pkg::*;
    logic       clk = 0, rst = 1, instr_valid = 0;
    logic       push, pc_load, flush;
    btsc_word_t instr = 12'h000, exec_word;
    btsc_pc_t   pc = 11'h000, return_stack_top, pc_target;
    logic [7:0] file_data = 8'h00, status = 8'h00;
    logic [4:0] file_addr;
    btsc_kind_t kind;
    int         n_mismatch = 0;
    int         cmp_count = 0;
    btsc_decode i_dut (.clk(clk), .rst(rst), .instr(instr),
        .instr_valid(instr_valid), .file_data(file_data), .status(status),
        .pc(pc), .file_addr(file_addr), .push(push),
        .return_stack_top(return_stack_top), .pc_load(pc_load),
        .pc_target(pc_target), .flush(flush), .exec_word(exec_word),
        .kind(kind));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [11:0] e, input logic [11:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // inputs change only by non-blocking assignment at the rising edge
    task automatic drive(input btsc_word_t w, input logic [7:0] fd);
        @(posedge clk);
        instr <= w;
        file_data <= fd;
        instr_valid <= 1'b1;
        #1;
    endtask
    task automatic test_bits();
        for (int b = 0; b < 8; b++) begin
            drive({4'h7, b[2:0], 5'(b * 4 + 3)}, 8'h01 << b);
            chk(12'(b * 4 + 3), 12'(file_addr));
            chk(12'(BTSC_KIND_TEST), 12'(kind));
            // a call in the slot after a taken skip must be swallowed
            drive(12'h9a5, 8'h00);
            chk(12'h001, 12'(flush));
            chk(12'h000, exec_word);
            chk(12'(BTSC_KIND_OTHER), 12'(kind));
            drive({4'h7, b[2:0], 5'h1f}, ~(8'h01 << b));
            chk(12'h000, 12'(push));
            drive(12'h0ab, 8'hff);
            chk(12'h000, 12'(flush));
            chk(12'h0ab, exec_word);
        end
        $display("test bits done");
    endtask
    task automatic test_call();
        for (int p = 0; p < 4; p++) begin
            @(posedge clk);
            status <= {1'b1, p[1:0], 5'h15};
            pc <= 11'(p * 300 + 5);
            drive({4'h9, 8'(p * 60 + 3)}, 8'h00);
            chk(12'(BTSC_KIND_CALL), 12'(kind));
            drive(12'h9ff, 8'h00);
            chk(12'h001, 12'(push));
            chk(12'h001, 12'(pc_load));
            chk(12'(p * 300 + 6), 12'(return_stack_top));
            chk({1'b0, p[1:0], 1'b0, 8'(p * 60 + 3)},
                12'(pc_target));
            chk(12'h001, 12'(flush));
            chk(12'h000, exec_word);
            drive(12'h000, 8'h00);
            chk(12'h000, 12'(push));
            chk(12'(p * 300 + 6), 12'(return_stack_top));
        end
        $display("test call done");
    endtask
    // reset in mid-run, then a call taken at the first edge after release
    task automatic test_reset();
        drive(12'h912, 8'h00);
        @(posedge clk);
        rst <= 1'b1;
        #1;
        chk(12'h000, 12'(push));
        chk(12'h000, 12'(flush));
        chk(12'h7ff, 12'(return_stack_top));
        @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(12'h7ff, 12'(pc_target));
        drive(12'h000, 8'h00);
        chk(12'h001, 12'(push));
        chk(12'(pc + 11'h001), 12'(return_stack_top));
        $display("test reset done");
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(12'h7ff, 12'(return_stack_top));
        chk(12'h000, 12'(push));
        test_bits();
        test_call();
        test_reset();
        results();
    end
    // far beyond the roughly 60 cycles the tests need
    initial begin
        #40000;
        n_mismatch++;
        results();
    end
endmodule
